// file: common/desc_parser_consts.vh
// Constants for the signalling descriptor parser
`ifndef DESC_PARSER_CONSTS_VH
`define DESC_PARSER_CONSTS_VH
// Register offsets (byte addresses)
`define REG_CTRL 12'h000
`define REG_POP_ID 12'h004
`define REG_LINK_TAG 12'h008
`define REG_CONT_TAG 12'h00C
`define REG_STATUS 12'h010
`define REG_TS_ONID 12'h014
`define REG_SVC_INET 12'h018
`define REG_CONT_INFO 12'h01C
`define REG_TID_BASE 12'h100
`define REG_TID_END 12'h500
`define TID_IDX_LSB 2
`define TID_IDX_MSB 9
// Reset values and the forward linkage type code
`define POP_ID_RST 16'h0000
`define LINK_TAG_RST 8'h4A
`define CONT_TAG_RST 8'hA0
`define FLS_LINKAGE 8'h81
// Control bit positions
`define CTRL_EN 0
`define CTRL_CLR 1
// Parser states
`define ST_TAG 4'h0
`define ST_LEN 4'h1
`define ST_TS 4'h2
`define ST_ONID 4'h3
`define ST_SVC 4'h4
`define ST_LTYPE 4'h5
`define ST_INET 4'h6
`define ST_LCNT 4'h7
`define ST_BASE 4'h8
`define ST_MASK 4'h9
`define ST_PRIV 4'hA
`define ST_TID 4'hB
`define ST_SKIP 4'hC
`endif

// file: rtl/byte_sync.v
// Two-stage synchroniser for the incoming byte stream strobe
`timescale 1ns/100ps
module byte_sync #(
   parameter W = 1
) (
   input wire pclk,
   input wire presetn,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   // First stage, read only by second stage
   reg [W-1:0] meta_q;
   // Two flops in series
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= {W{1'b0}};
         q <= {W{1'b0}};
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// file: rtl/range_match.v
// Masked compare of the terminal population id against one range
`timescale 1ns/100ps
module range_match (
   input wire [15:0] pop_id,
   input wire [15:0] base,
   input wire [15:0] mask,
   output wire hit
);
   // Mask bits set are don't care; clear bits must equal base
   assign hit = (((pop_id ^ base) & ~mask) == 16'h0000); // R10 R11
endmodule

// file: rtl/desc_parser.v
// Linkage and content descriptor parser with APB register access
`timescale 1ns/100ps
`include "desc_parser_consts.vh"
// Overview: bytes from the upstream section extractor arrive as a level strobe.
// Each rising strobe edge hands one byte to the parser. The parser walks the fixed
// field order of the selected descriptor layout and counts down the length byte.
// Linkage descriptors yield stream, network and service identifiers plus a
// population match against the configured terminal id.
// Content descriptors store their table ids for software to read back.
// Any other tag is skipped by its length, so the stream stays aligned.
// A linkage length that ends before its last range completes flags an error in the status word.
// Results sit in registers that are reached over the register bus.
// Functional notes
// R1: First byte is tag selecting layout
// R2: Second byte is length bounding parse
// R3: Extract 16-bit transport stream id
// R4: Extract 16-bit original network id
// R5: Extract 16-bit service id
// R6: Linkage type 0x81 marks forward link
// R7: Extract 16-bit interactive network id
// R8: Loop count plus one range pairs
// R9: Each range is base then mask
// R10: Mask bit one ignores id bit
// R11: Mask bit zero requires id equal base
// R12: Population id is preset configuration
// R13: Trailing bytes are private, skipped
// R14: Content bytes are table identifiers
// R15: Table ids tied to one stream
// R16: Accept content in stream loop
// R17: Never require content descriptor
// R18: Reserved bits are ignored
// R19: Private data selects serving network; the code skips private bytes unread and always presents inet_q
// R20: Match flag presents network identifiers
// R21: Fields MSB first, fixed order
module desc_parser (
   input wire pclk,
   input wire presetn,
   input wire [31:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire byte_valid,
   input wire [7:0] byte_data,
   input wire [12:0] es_pid,
   output reg match_q,
   output reg [15:0] inet_id_q,
   output reg content_done_q
);
   // Synchronised stream inputs
   // Strobe, data and stream id share one two-flop chain, so the data is
   // sampled in the same cycle as the strobe edge that it belongs to
   wire byte_valid_s;
   wire [7:0] byte_data_s;
   wire [12:0] es_pid_s;
   byte_sync #(.W(22)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({byte_valid, byte_data, es_pid}),
      .q({byte_valid_s, byte_data_s, es_pid_s})
   );
   // Registered valid for edge detect of strobe
   // Resets low like the idle strobe, so no false edge follows reset
   reg valid_prev_q;
   wire take = byte_valid_s & ~valid_prev_q;
   // Configuration registers
   // Enable, population id and the two tag values are software settings
   reg en_q;
   reg [15:0] pop_id_q;
   reg [7:0] link_tag_q;
   reg [7:0] cont_tag_q;
   // Parser state
   // remain_q counts the bytes left in the descriptor after the length byte
   // hi_q marks the second byte of a two-byte field
   reg [3:0] state_q;
   reg [7:0] remain_q;
   reg hi_q;
   reg [7:0] hold_q;
   reg [7:0] lcnt_q;
   reg [15:0] base_q;
   reg is_link_q;
   // Captured fields
   // Kept until the next descriptor of the same kind overwrites them, link_done_q and err_q until a software clear; every length byte clears tid_cnt_q and any_hit_q
   reg [15:0] ts_q;
   reg [15:0] onid_q;
   reg [15:0] svc_q;
   reg [7:0] ltype_q;
   reg [15:0] inet_q;
   reg any_hit_q;
   reg link_done_q;
   reg err_q;
   reg [12:0] cont_pid_q;
   reg [7:0] tid_cnt_q;
   reg [7:0] tid_mem [0:255];
   // Table id window decode: the entry index counts from the window base
   wire [11:0] tid_off = paddr[11:0] - `REG_TID_BASE;
   // Addresses past the last entry fall through to the error decode
   wire in_tid = (paddr[11:0] >= `REG_TID_BASE) && (paddr[11:0] < `REG_TID_END);
   // Byte forming a 16-bit word with the held high byte
   wire [15:0] word = {hold_q, byte_data_s};
   // Range comparator
   // Compares against the mask that the current byte completes
   wire hit;
   range_match u_match (
      .pop_id(pop_id_q),
      .base(base_q),
      .mask(word),
      .hit(hit)
   );
   // APB decode
   // apb_wr is true only at the edge where a write completes
   wire apb_wr = psel & penable & pwrite & pready;
   wire ctrl_clr = apb_wr & (paddr[11:0] == `REG_CTRL) & pwdata[`CTRL_CLR];
   wire last = (remain_q == 8'h01);
   // Descriptor parse state machine
   // The tag and length bytes do not count against the length; every later
   // byte does, and the byte that brings the count to zero ends the descriptor
   // wherever the walk stands. A linkage descriptor that ends before its last
   // mask byte is flagged as short; bytes left after the ranges are private.
   // A software clear and a parser set in the same cycle leave the flag set,
   // because the set assignments come later in this process.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Edge detector and walk position
         valid_prev_q <= 1'b0;
         state_q <= `ST_TAG;
         remain_q <= 8'h00;
         hi_q <= 1'b0;
         hold_q <= 8'h00;
         lcnt_q <= 8'h00;
         base_q <= 16'h0000;
         is_link_q <= 1'b0;
         // Captured fields
         ts_q <= 16'h0000;
         onid_q <= 16'h0000;
         svc_q <= 16'h0000;
         ltype_q <= 8'h00;
         inet_q <= 16'h0000;
         any_hit_q <= 1'b0;
         link_done_q <= 1'b0;
         err_q <= 1'b0;
         cont_pid_q <= 13'h0000;
         tid_cnt_q <= 8'h00;
         // Outputs start low
         match_q <= 1'b0;
         inet_id_q <= 16'h0000;
         content_done_q <= 1'b0;
      end else begin
         valid_prev_q <= byte_valid_s;
         content_done_q <= 1'b0;
         // Software clear of results; parser set wins
         if (ctrl_clr) begin
            match_q <= 1'b0;
            link_done_q <= 1'b0;
            err_q <= 1'b0;
         end
         if (take && en_q) begin
            if (state_q != `ST_TAG && state_q != `ST_LEN)
               remain_q <= remain_q - 8'h01; // R2
            case (state_q)
               `ST_TAG: begin
                  // Tag picks layout; other tags are skipped via length
                  // hold_q carries the layout code into the length state
                  is_link_q <= (byte_data_s == link_tag_q); // R1
                  if (byte_data_s == link_tag_q || byte_data_s == cont_tag_q) begin
                     state_q <= `ST_LEN;
                  end else begin
                     state_q <= `ST_LEN;
                     hold_q <= 8'hFF;
                  end
                  if (byte_data_s == cont_tag_q)
                     hold_q <= 8'h01;
                  else if (byte_data_s == link_tag_q)
                     hold_q <= 8'h00;
               end
               `ST_LEN: begin
                  remain_q <= byte_data_s; // R2
                  hi_q <= 1'b0;
                  any_hit_q <= 1'b0;
                  tid_cnt_q <= 8'h00;
                  if (byte_data_s == 8'h00) begin
                     // Empty descriptor ends at its length byte
                     state_q <= `ST_TAG;
                     if (hold_q == 8'h01)
                        content_done_q <= 1'b1;
                  end else if (hold_q == 8'h00) begin
                     // Linkage layout starts with the transport stream id
                     state_q <= `ST_TS; // R21
                  end else if (hold_q == 8'h01) begin
                     // Content layout: all entries belong to this stream id
                     cont_pid_q <= es_pid_s; // R15 R16
                     state_q <= `ST_TID;
                  end else begin
                     // Unknown tag: consume its bytes without looking at them
                     state_q <= `ST_SKIP;
                  end
               end
               `ST_TS, `ST_ONID, `ST_SVC, `ST_INET, `ST_BASE, `ST_MASK: begin
                  // Two-byte fields, high byte first
                  hi_q <= ~hi_q;
                  if (!hi_q) begin
                     hold_q <= byte_data_s; // R21
                  end else begin
                     case (state_q)
                        `ST_TS: ts_q <= word; // R3
                        `ST_ONID: onid_q <= word; // R4
                        `ST_SVC: svc_q <= word; // R5
                        `ST_INET: inet_q <= word; // R7
                        `ST_BASE: base_q <= word; // R9
                        default: begin
                           // Mask byte completes a range
                           if (hit && ltype_q == `FLS_LINKAGE)
                              any_hit_q <= 1'b1; // R10 R11 R19
                        end
                     endcase
                     // Field that follows a completed word
                     if (state_q == `ST_SVC)
                        state_q <= `ST_LTYPE;
                     else if (state_q == `ST_INET)
                        state_q <= `ST_LCNT;
                     else if (state_q == `ST_BASE)
                        state_q <= `ST_MASK;
                     else if (state_q == `ST_MASK)
                        state_q <= (lcnt_q == 8'h00) ? `ST_PRIV : `ST_BASE; // R8
                     else
                        state_q <= state_q + 4'h1;
                     // One base and mask pair consumed
                     if (state_q == `ST_MASK)
                        lcnt_q <= lcnt_q - 8'h01;
                  end
               end
               `ST_LTYPE: begin
                  // Only the forward link type allows a match
                  ltype_q <= byte_data_s; // R6
                  state_q <= `ST_INET;
               end
               `ST_LCNT: begin
                  // Count holds the number of ranges minus one
                  lcnt_q <= byte_data_s; // R8
                  state_q <= `ST_BASE;
               end
               `ST_TID: begin
                  // Entry count doubles as the store index
                  tid_cnt_q <= tid_cnt_q + 8'h01; // R14
               end
               default: begin
                  // Private or unknown bytes pass without interpretation
                  state_q <= state_q; // R13 R18
               end
            endcase
            // Descriptor end bounded by length
            // Comes after the case, so its state update overrides the walk
            if (state_q != `ST_TAG && state_q != `ST_LEN && last) begin
               state_q <= `ST_TAG;
               // Content descriptor finished: one-cycle pulse
               if (state_q == `ST_TID)
                  content_done_q <= 1'b1; // R15
               if (is_link_q) begin
                  link_done_q <= 1'b1;
                  // Short descriptor: ranges not complete
                  // Complete means the last mask byte of the final range
                  if (state_q != `ST_PRIV && !(state_q == `ST_MASK && hi_q && lcnt_q == 8'h00))
                     err_q <= 1'b1;
                  // Present match with the interactive network id
                  // A hit on the closing range counts as well as an earlier one
                  if (state_q == `ST_MASK && hit && ltype_q == `FLS_LINKAGE && hi_q)
                     match_q <= 1'b1; // R20
                  else if (any_hit_q)
                     match_q <= 1'b1; // R20
                  if (any_hit_q || (state_q == `ST_MASK && hit && hi_q
                        && ltype_q == `FLS_LINKAGE))
                     inet_id_q <= inet_q; // R20
               end
            end
         end
      end
   end
   // Table id store, one byte per entry
   // No reset: entries are only read back after a content descriptor wrote them
   always @(posedge pclk) begin
      if (take && en_q && state_q == `ST_TID)
         tid_mem[tid_cnt_q] <= byte_data_s; // R14
   end
   // Register writes; population id held by software before use
   // Writes land at the edge where pready is seen with the access phase
   // The clear bit of the control word is handled in the parse process
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= 1'b1;
         pop_id_q <= `POP_ID_RST;
         link_tag_q <= `LINK_TAG_RST;
         cont_tag_q <= `CONT_TAG_RST;
      end else if (apb_wr) begin
         case (paddr[11:0])
            `REG_CTRL: en_q <= pwdata[`CTRL_EN]; // R17
            `REG_POP_ID: pop_id_q <= pwdata[15:0]; // R12
            `REG_LINK_TAG: link_tag_q <= pwdata[7:0];
            `REG_CONT_TAG: cont_tag_q <= pwdata[7:0];
            default: en_q <= en_q;
         endcase
      end
   end
   // APB answer: one wait state, read data registered
   // pready rises one edge into the access phase and drops at the next edge,
   // so a request still held after pready sees pready rise again two edges later
   // Read data and pslverr stand only while pready is high
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (psel & penable & ~pready) begin
            if (in_tid) begin
               // Table id window is read only; writes are dropped quietly
               if (!pwrite)
                  prdata <= {24'h00_0000, tid_mem[tid_off[`TID_IDX_MSB:`TID_IDX_LSB]]};
            end else if (!pwrite) begin
               // Register read mux; unmapped offsets answer with an error
               case (paddr[11:0])
                  `REG_CTRL: prdata <= {31'h0000_0000, en_q};
                  `REG_POP_ID: prdata <= {16'h0000, pop_id_q};
                  `REG_LINK_TAG: prdata <= {24'h00_0000, link_tag_q};
                  `REG_CONT_TAG: prdata <= {24'h00_0000, cont_tag_q};
                  `REG_STATUS: prdata <= {16'h0000, ltype_q, 5'h00, err_q, link_done_q, match_q};
                  `REG_TS_ONID: prdata <= {ts_q, onid_q};
                  `REG_SVC_INET: prdata <= {svc_q, inet_q};
                  `REG_CONT_INFO: prdata <= {11'h000, cont_pid_q, tid_cnt_q};
                  default: pslverr <= 1'b1;
               endcase
            end else begin
               // Only the four settings registers accept writes
               case (paddr[11:0])
                  `REG_CTRL, `REG_POP_ID, `REG_LINK_TAG, `REG_CONT_TAG: pslverr <= 1'b0;
                  default: pslverr <= 1'b1;
               endcase
            end
         end
      end
   end
endmodule

// file: bench/desc_parser_props.sv
// Checker for the descriptor parser ports
`timescale 1ns/100ps
module desc_parser_props (
   input wire pclk,
   input wire presetn,
   input wire [31:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire byte_valid,
   input wire [7:0] byte_data,
   input wire [12:0] es_pid,
   input wire match_q,
   input wire [15:0] inet_id_q,
   input wire content_done_q
);
   reg bv_q; // Strobe level at the previous edge
   reg [3:0] since_q; // Edges since the strobe last rose, saturating
   // Parse results may only move shortly after a byte arrives
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bv_q <= 1'b0;
         since_q <= 4'hF;
      end else begin
         bv_q <= byte_valid;
         if (byte_valid && !bv_q) begin
            since_q <= 4'h0;
         end else if (since_q != 4'hF) begin
            since_q <= since_q + 4'h1;
         end
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ready_wait;
      psel && penable && !pready |=> pready;
   endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("pready late");
   property p_ready_pulse;
      pready |-> psel && penable ##1 !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready stray");
   property p_err_ready;
      pslverr |-> pready;
   endproperty
   a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
   property p_done_pulse;
      content_done_q |=> !content_done_q;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done too long");
   property p_done_cause;
      content_done_q |-> since_q <= 4'd6;
   endproperty
   a_done_cause: assert property (p_done_cause) else $error("done without byte");
   property p_match_cause;
      $rose(match_q) |-> since_q <= 4'd6;
   endproperty
   a_match_cause: assert property (p_match_cause) else $error("match without byte");
   property p_inet_match;
      $changed(inet_id_q) |-> match_q && since_q <= 4'd6;
   endproperty
   a_inet_match: assert property (p_inet_match) else $error("inet id moved");
   property p_match_fall;
      $fell(match_q) |-> $past(psel && pwrite) || since_q <= 4'd6;
   endproperty
   a_match_fall: assert property (p_match_fall) else $error("match dropped");
endmodule
bind desc_parser desc_parser_props u_props (.pclk(pclk), .presetn(presetn), .paddr(paddr),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .byte_valid(byte_valid), .byte_data(byte_data),
   .es_pid(es_pid), .match_q(match_q), .inet_id_q(inet_id_q),
   .content_done_q(content_done_q));

// file: bench/byte_source.sv
// Upstream section extractor model handing out descriptor bytes
`timescale 1ns/100ps
module byte_source (
   input wire pclk,
   output logic byte_valid,
   output logic [7:0] byte_data
);
   int gap = 4; // Cycles per strobe phase, raised for a slow source
   initial begin
      byte_valid = 1'b0;
      byte_data = 8'h00;
   end
   // One byte per strobe; idle data shows the inverse so stale bytes never match
   task send(input logic [7:0] b);
      @(posedge pclk);
      byte_valid <= 1'b1;
      byte_data <= b;
      repeat (gap) @(posedge pclk);
      byte_valid <= 1'b0;
      byte_data <= ~b;
      repeat (gap - 1) @(posedge pclk);
   endtask
endmodule

// file: bench/rcs_linkage_content_descriptor_parser_bench.sv
// Testbench for the descriptor parser
`timescale 1ns/100ps
`include "desc_parser_consts.vh"
module rcs_linkage_content_descriptor_parser_bench;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
   logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, rd;
   logic [12:0] es_pid = 13'h0000;
   logic [7:0] q[$]; // Bytes waiting to be sent
   wire bv, pready, pslverr, match_q, content_done_q;
   wire [7:0] bd;
   wire [31:0] prdata;
   wire [15:0] inet_id_q;
   int err_count = 0, checked = 0, cyc = 0, dones = 0;
   initial forever #25 pclk = ~pclk;
   desc_parser u_desc_parser (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .byte_valid(bv), .byte_data(bd), .es_pid(es_pid),
      .match_q(match_q), .inet_id_q(inet_id_q), .content_done_q(content_done_q));
   byte_source u_byte_source (.pclk(pclk), .byte_valid(bv), .byte_data(bd));
   task wrap_up;
      if (err_count == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Cycle ceiling and done pulse count
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (content_done_q === 1'b1) dones <= dones + 1;
      if (cyc == 30000) begin
         err_count++;
         wrap_up;
      end
   end
   task chk(input string n, input logic [31:0] x, input logic [31:0] g);
      checked++;
      if (g !== x) begin
         $display("[FAIL] %s exp %h got %h", n, x, g);
         err_count++;
      end
   endtask
   // One APB transfer, held until pready is seen
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task send_q;
      foreach (q[i]) u_byte_source.send(q[i]);
      q = {};
      repeat (6) @(posedge pclk);
   endtask
   // Single-range linkage; network id is the inverted base
   task link(input logic [7:0] lt, input logic [15:0] b, input logic [15:0] m, input logic x);
      logic [15:0] n;
      n = ~b;
      q = {8'h4A, 8'h0E, 8'h11, 8'h11, 8'h22, 8'h22, 8'h33, 8'h33, lt, n[15:8], n[7:0],
         8'h00, b[15:8], b[7:0], m[15:8], m[7:0]};
      send_q;
      chk("match", x, match_q);
      if (x) chk("inet", n, inet_id_q);
      apb(1'b1, `REG_CTRL, 32'h0000_0003);
      repeat (2) @(posedge pclk);
      chk("cleared", 32'h0000_0000, match_q);
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `REG_POP_ID, 32'h0000_0000);
      chk("pop_id", 32'h0000_0000, rd);
      apb(1'b0, `REG_LINK_TAG, 32'h0000_0000);
      chk("link_tag", 32'h0000_004A, rd);
      apb(1'b0, `REG_CONT_TAG, 32'h0000_0000);
      chk("cont_tag", 32'h0000_00A0, rd);
      apb(1'b0, 32'h0000_0FFC, 32'h0000_0000);
      chk("slverr", 32'h0000_0001, e);
      apb(1'b1, `REG_POP_ID, 32'h0000_1234);
      apb(1'b1, `REG_CTRL, 32'h0000_0002);
      link(8'h81, 16'h1234, 16'h0000, 1'b0);
      link(8'h81, 16'h1234, 16'h0000, 1'b1);
      link(8'h81, 16'h1235, 16'h0000, 1'b0);
      link(8'h81, 16'h12F0, 16'h00FF, 1'b1);
      link(8'h81, 16'h0000, 16'hFFFF, 1'b1);
      link(8'h82, 16'h1234, 16'h0000, 1'b0);
      u_byte_source.gap = 8;
      q = {8'h4A, 8'h14, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9A, 8'hBC, 8'h81, 8'hC0, 8'h01,
         8'h01, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h12, 8'h00, 8'h00, 8'hFF, 8'h77, 8'h88};
      send_q;
      u_byte_source.gap = 4;
      chk("match2", 32'h0000_0001, match_q);
      chk("inet2", 32'h0000_C001, inet_id_q);
      apb(1'b0, `REG_STATUS, 32'h0000_0000);
      chk("status", 32'h0000_8103, rd);
      apb(1'b0, `REG_TS_ONID, 32'h0000_0000);
      chk("ts_onid", 32'h1234_5678, rd);
      apb(1'b0, `REG_SVC_INET, 32'h0000_0000);
      chk("svc_inet", 32'h9ABC_C001, rd);
      es_pid <= 13'h1ABC;
      q = {8'h55, 8'h02, 8'hA0, 8'h03, 8'hA0, 8'h03, 8'h40, 8'h41, 8'h42};
      send_q;
      chk("dones", 32'h0000_0001, dones);
      chk("match_kept", 32'h0000_0001, match_q);
      apb(1'b0, `REG_CONT_INFO, 32'h0000_0000);
      chk("cont_info", 32'h001A_BC03, rd);
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, `REG_TID_BASE + 4 * i, 32'h0000_0000);
         chk("tid", 32'h0000_0040 + i, rd);
      end
      apb(1'b1, `REG_CTRL, 32'h0000_0003);
      q = {8'h4A, 8'h0A, 8'h21, 8'h43, 8'h65, 8'h87, 8'hA9, 8'hCB, 8'h81, 8'h0F, 8'hED, 8'h00};
      send_q;
      apb(1'b0, `REG_STATUS, 32'h0000_0000);
      chk("short", 32'h0000_8106, rd);
      apb(1'b0, `REG_TS_ONID, 32'h0000_0000);
      chk("ts_onid2", 32'h2143_6587, rd);
      wrap_up;
   end
endmodule
